// >>> core/dar_pkg.sv
// constants and types for the 40-bit accumulator datapath
package dar_pkg;
  localparam int ACC_W = 40;
  // register byte offsets on the avalon slave
  localparam logic [4:0] ADDR_CORE_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TRAP_CTRL = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_WB_PTR = 5'h0c;
  localparam logic [4:0] ADDR_ACC_A_LO = 5'h10;
  localparam logic [4:0] ADDR_ACC_A_HI = 5'h14;
  localparam logic [4:0] ADDR_ACC_B_LO = 5'h18;
  localparam logic [4:0] ADDR_ACC_B_HI = 5'h1c;
  // core_control_reg fields
  localparam int CC_CLIP_A = 7;
  localparam int CC_CLIP_B = 6;
  localparam int CC_STORE_CLIP = 5;
  localparam int CC_CLIP_WIDTH = 4;
  localparam int CC_ROUND_KIND = 1;
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  // interrupt_control_reg_one fields
  localparam int TC_GUARD_A = 0;
  localparam int TC_GUARD_B = 1;
  localparam int TC_FATAL = 2;
  localparam logic [2:0] TRAP_CTRL_RST = 3'h0;
  // status fields
  localparam int ST_GUARD_A = 0;
  localparam int ST_GUARD_B = 1;
  localparam int ST_LIMIT_A = 2;
  localparam int ST_LIMIT_B = 3;
  localparam int ST_GUARD_ANY = 4;
  localparam int ST_LIMIT_ANY = 5;
  // saturation, store clipping, rounding, write-back step and reset values
  localparam logic [39:0] SAT931_POS = 40'h7fffffffff;
  localparam logic [39:0] SAT931_NEG = 40'h8000000000;
  localparam logic [39:0] SAT131_POS = 40'h007fffffff;
  localparam logic [39:0] SAT131_NEG = 40'h0080000000;
  localparam logic [23:0] STORE_POS_LIMIT = 24'h007fff;
  localparam logic [23:0] STORE_NEG_LIMIT = 24'hff8000;
  localparam logic [15:0] STORE_MAX = 16'h7fff;
  localparam logic [15:0] STORE_MIN = 16'h8000;
  localparam logic [15:0] ROUND_HALF = 16'h8000;
  localparam logic [15:0] WB_STEP = 16'h0002;
  localparam logic [15:0] WB_PTR_RST = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h0000000000;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_LOAD = 4'h3,
    OP_MAC = 4'h4, OP_MSC = 4'h5, OP_PROD = 4'h6, OP_PROD_NEG = 4'h7,
    OP_DSQ = 4'h8, OP_DSQ_ACC = 4'h9, OP_ACC_ADD = 4'ha, OP_ACC_SUB = 4'hb,
    OP_ACC_NEG = 4'hc, OP_CLR = 4'hd, OP_STORE = 4'he, OP_STORE_ROUND = 4'hf
  } dar_op_t;
  typedef enum logic [1:0] {
    WB_NONE = 2'h0, WB_DIRECT = 2'h1, WB_INDIRECT = 2'h2
  } dar_wb_t;
endpackage : dar_pkg

// >>> core/dar_accumulator.sv
// 40-bit accumulator adder with saturation, rounding and store clipping
`timescale 1ns/1ps
module dar_accumulator (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // operation from the instruction decoder
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic op_target_b,
  input wire logic [39:0] op_operand,
  input wire logic op_scale,
  input wire logic [5:0] op_shift,
  input wire logic op_carry_in,
  input wire logic [1:0] op_wb_mode,
  input wire logic [15:0] op_addr,
  // x bus data write
  output logic xbus_write,
  output logic [15:0] xbus_addr,
  output logic [15:0] xbus_data,
  // pointer and trap
  output logic [15:0] writeback_pointer,
  output logic arith_trap
);
  typedef struct packed {
    logic [7:0] core_control_reg;
    logic [2:0] interrupt_control_reg_one;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic guard_overflow_a;
    logic guard_overflow_b;
    logic limit_hit_a;
    logic limit_hit_b;
    logic [15:0] wb_ptr;
    logic xbus_write;
    logic [15:0] xbus_addr;
    logic [15:0] xbus_data;
    logic arith_trap;
    logic waitrequest;
    logic [31:0] readdata;
  } dar_state_t;

  dar_state_t r;
  dar_state_t next_r;

  // signed shift: positive right arithmetic, negative left
  function automatic logic [39:0] shift40(input logic [39:0] v, input logic [5:0] sh);
    logic [5:0] mag;
    mag = sh[5] ? 6'(-sh) : sh;
    if (sh[5]) begin
      shift40 = v << mag;
    end else begin
      shift40 = 40'($signed(v) >>> mag);
    end
  endfunction : shift40

  // round or truncate, then optional 1.15 clipping
  function automatic logic [15:0] store_value(input logic [39:0] acc, input logic do_round,
                                              input logic conventional, input logic clip);
    logic inc;
    logic [23:0] r24;
    inc = do_round && acc[15] && (conventional || acc[15:0] != dar_pkg::ROUND_HALF || acc[16]);
    r24 = acc[39:16] + {23'h000000, inc};
    if (clip && !acc[39] && r24 > dar_pkg::STORE_POS_LIMIT) begin
      store_value = dar_pkg::STORE_MAX;
    end else if (clip && acc[39] && r24[23] && r24 < dar_pkg::STORE_NEG_LIMIT) begin
      store_value = dar_pkg::STORE_MIN;
    end else begin
      store_value = r24[15:0];
    end
  endfunction : store_value

  logic [39:0] tgt;
  logic [39:0] oth;
  logic [39:0] opnd;
  logic [39:0] bsrc;
  logic [39:0] opa;
  logic [39:0] bx;
  logic [40:0] sum;
  logic use_adder;
  logic zero_a;
  logic sub;
  logic cin;
  logic ov39;
  logic ov31;
  logic guard_ov;
  logic clip_en;
  logic [39:0] new_acc;
  logic limit_set;
  logic guard_new;
  logic trap;
  logic wb_ok;
  logic [15:0] wb_val;
  logic [31:0] rd;

  always_comb begin
    next_r = r;
    next_r.xbus_write = 1'b0;
    next_r.arith_trap = 1'b0;
    rd = 32'h00000000;
    // one wait state, then the access completes
    next_r.waitrequest = !((avs_read || avs_write) && r.waitrequest);
    if (avs_address == dar_pkg::ADDR_CORE_CTRL) begin
      rd = {24'h000000, r.core_control_reg};
    end else if (avs_address == dar_pkg::ADDR_TRAP_CTRL) begin
      rd = {29'h00000000, r.interrupt_control_reg_one};
    end else if (avs_address == dar_pkg::ADDR_STATUS) begin
      rd[dar_pkg::ST_GUARD_A] = r.guard_overflow_a;
      rd[dar_pkg::ST_GUARD_B] = r.guard_overflow_b;
      rd[dar_pkg::ST_LIMIT_A] = r.limit_hit_a;
      rd[dar_pkg::ST_LIMIT_B] = r.limit_hit_b;
      rd[dar_pkg::ST_GUARD_ANY] = r.guard_overflow_a | r.guard_overflow_b;
      rd[dar_pkg::ST_LIMIT_ANY] = r.limit_hit_a | r.limit_hit_b;
    end else if (avs_address == dar_pkg::ADDR_WB_PTR) begin
      rd = {16'h0000, r.wb_ptr};
    end else if (avs_address == dar_pkg::ADDR_ACC_A_LO) begin
      rd = r.acc_a[31:0];
    end else if (avs_address == dar_pkg::ADDR_ACC_A_HI) begin
      rd = {24'h000000, r.acc_a[39:32]};
    end else if (avs_address == dar_pkg::ADDR_ACC_B_LO) begin
      rd = r.acc_b[31:0];
    end else if (avs_address == dar_pkg::ADDR_ACC_B_HI) begin
      rd = {24'h000000, r.acc_b[39:32]};
    end
    if (avs_read && r.waitrequest) begin
      next_r.readdata = rd;
    end
    if (avs_write && !r.waitrequest) begin
      if (avs_address == dar_pkg::ADDR_CORE_CTRL) begin
        next_r.core_control_reg = avs_writedata[7:0];
      end else if (avs_address == dar_pkg::ADDR_TRAP_CTRL) begin
        next_r.interrupt_control_reg_one = avs_writedata[2:0];
      end else if (avs_address == dar_pkg::ADDR_STATUS) begin
        // write one to clear the limit flags only; a same-cycle set below wins
        if (avs_writedata[dar_pkg::ST_LIMIT_A]) begin
          next_r.limit_hit_a = 1'b0;
        end
        if (avs_writedata[dar_pkg::ST_LIMIT_B]) begin
          next_r.limit_hit_b = 1'b0;
        end
      end else if (avs_address == dar_pkg::ADDR_WB_PTR) begin
        next_r.wb_ptr = avs_writedata[15:0];
      end
    end

    tgt = op_target_b ? r.acc_b : r.acc_a;
    oth = op_target_b ? r.acc_a : r.acc_b;
    opnd = (op_scale && (op_code == dar_pkg::OP_ADD || op_code == dar_pkg::OP_LOAD)) ?
           shift40(op_operand, op_shift) : op_operand;
    use_adder = 1'b0;
    zero_a = 1'b0;
    sub = 1'b0;
    bsrc = opnd;
    cin = op_carry_in;
    wb_ok = 1'b0;
    case (op_code)
      dar_pkg::OP_ADD, dar_pkg::OP_DSQ_ACC: begin
        use_adder = 1'b1;
      end
      dar_pkg::OP_MAC: begin
        use_adder = 1'b1;
        wb_ok = 1'b1;
      end
      dar_pkg::OP_SUB: begin
        use_adder = 1'b1;
        sub = 1'b1;
      end
      dar_pkg::OP_MSC: begin
        use_adder = 1'b1;
        sub = 1'b1;
        wb_ok = 1'b1;
      end
      dar_pkg::OP_LOAD, dar_pkg::OP_PROD, dar_pkg::OP_DSQ: begin
        use_adder = 1'b1;
        zero_a = 1'b1;
      end
      dar_pkg::OP_PROD_NEG: begin
        use_adder = 1'b1;
        zero_a = 1'b1;
        sub = 1'b1;
      end
      dar_pkg::OP_ACC_ADD: begin
        use_adder = 1'b1;
        bsrc = oth;
      end
      dar_pkg::OP_ACC_SUB: begin
        use_adder = 1'b1;
        sub = 1'b1;
        bsrc = oth;
      end
      dar_pkg::OP_ACC_NEG: begin
        use_adder = 1'b1;
        zero_a = 1'b1;
        sub = 1'b1;
        bsrc = tgt;
      end
      dar_pkg::OP_CLR: begin
        use_adder = 1'b1;
        zero_a = 1'b1;
        bsrc = dar_pkg::ACC_RST;
        cin = 1'b0;
        wb_ok = 1'b1;
      end
      default: begin
      end
    endcase
    opa = zero_a ? dar_pkg::ACC_RST : tgt;
    bx = sub ? ~bsrc : bsrc;
    sum = {opa[39], opa} + {bx[39], bx} + {40'h0000000000, cin};
    ov39 = sum[40] ^ sum[39];
    ov31 = !(&sum[40:31] || ~|sum[40:31]);
    guard_ov = !(&sum[39:32] || ~|sum[39:32]);
    clip_en = op_target_b ? r.core_control_reg[dar_pkg::CC_CLIP_B] :
              r.core_control_reg[dar_pkg::CC_CLIP_A];
    new_acc = sum[39:0];
    limit_set = 1'b0;
    guard_new = guard_ov;
    trap = 1'b0;
    if (clip_en && r.core_control_reg[dar_pkg::CC_CLIP_WIDTH]) begin
      if (ov39) begin
        new_acc = sum[40] ? dar_pkg::SAT931_NEG : dar_pkg::SAT931_POS;
        limit_set = 1'b1;
      end
    end else if (clip_en) begin
      guard_new = 1'b0;
      if (ov31) begin
        new_acc = sum[40] ? dar_pkg::SAT131_NEG : dar_pkg::SAT131_POS;
        limit_set = 1'b1;
      end
    end else begin
      limit_set = ov39;
      trap = ov39 && r.interrupt_control_reg_one[dar_pkg::TC_FATAL];
    end
    if (guard_new && r.interrupt_control_reg_one[op_target_b ? dar_pkg::TC_GUARD_B :
                                                  dar_pkg::TC_GUARD_A]) begin
      trap = 1'b1;
    end
    wb_val = store_value(oth, 1'b1, r.core_control_reg[dar_pkg::CC_ROUND_KIND],
                         r.core_control_reg[dar_pkg::CC_STORE_CLIP]);
    if (op_valid && use_adder) begin
      next_r.arith_trap = trap;
      if (op_target_b) begin
        next_r.acc_b = new_acc;
        next_r.guard_overflow_b = guard_new;
        next_r.limit_hit_b = next_r.limit_hit_b | limit_set;
      end else begin
        next_r.acc_a = new_acc;
        next_r.guard_overflow_a = guard_new;
        next_r.limit_hit_a = next_r.limit_hit_a | limit_set;
      end
      if (wb_ok && op_wb_mode == dar_pkg::WB_DIRECT) begin
        next_r.wb_ptr = wb_val;
      end else if (wb_ok && op_wb_mode == dar_pkg::WB_INDIRECT) begin
        next_r.xbus_write = 1'b1;
        next_r.xbus_addr = r.wb_ptr;
        next_r.xbus_data = wb_val;
        next_r.wb_ptr = r.wb_ptr + dar_pkg::WB_STEP;
      end
    end
    if (op_valid && (op_code == dar_pkg::OP_STORE || op_code == dar_pkg::OP_STORE_ROUND)) begin
      next_r.xbus_write = 1'b1;
      next_r.xbus_addr = op_addr;
      next_r.xbus_data = store_value(tgt, op_code == dar_pkg::OP_STORE_ROUND,
                                     r.core_control_reg[dar_pkg::CC_ROUND_KIND],
                                     r.core_control_reg[dar_pkg::CC_STORE_CLIP]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.core_control_reg <= dar_pkg::CORE_CTRL_RST;
      r.interrupt_control_reg_one <= dar_pkg::TRAP_CTRL_RST;
      r.wb_ptr <= dar_pkg::WB_PTR_RST;
      r.waitrequest <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = r.readdata;
  assign avs_waitrequest = r.waitrequest;
  assign xbus_write = r.xbus_write;
  assign xbus_addr = r.xbus_addr;
  assign xbus_data = r.xbus_data;
  assign writeback_pointer = r.wb_ptr;
  assign arith_trap = r.arith_trap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic op_a;
  logic clr_a;
  assign op_a = op_valid && !op_target_b;
  assign clr_a = avs_write && !r.waitrequest && avs_address == dar_pkg::ADDR_STATUS &&
                 avs_writedata[dar_pkg::ST_LIMIT_A];
  AST_LIMIT_STICKY: assert property (r.limit_hit_a && !clr_a |=> r.limit_hit_a)
    else $error("limit flag of acc A cleared without a software write");
  AST_SAT131_RANGE: assert property (op_a && use_adder && r.core_control_reg[7:6] == 2'b10 &&
    !r.core_control_reg[dar_pkg::CC_CLIP_WIDTH] |=> !r.guard_overflow_a)
    else $error("guard flag set in 1.31 mode");
  AST_WRAP_FLAG: assert property (op_a && use_adder && !clip_en && ov39 |=>
    r.limit_hit_a && r.acc_a == $past(sum[39:0]))
    else $error("catastrophic overflow not flagged or accumulator not wrapped");
  AST_FATAL_TRAP: assert property (op_valid && use_adder && !clip_en && ov39 &&
    r.interrupt_control_reg_one[dar_pkg::TC_FATAL] |=> arith_trap ##1 !arith_trap)
    else $error("fatal overflow trap missing or not a pulse");
  AST_STORE_TRUNC: assert property (op_a && op_code == dar_pkg::OP_STORE &&
    !r.core_control_reg[dar_pkg::CC_STORE_CLIP] |=> xbus_write &&
    xbus_data == $past(r.acc_a[31:16]))
    else $error("truncated store value wrong");
  AST_ROUND_CONV: assert property (op_a && op_code == dar_pkg::OP_STORE_ROUND &&
    r.core_control_reg[dar_pkg::CC_ROUND_KIND] && !r.core_control_reg[dar_pkg::CC_STORE_CLIP] &&
    r.acc_a[15] |=> xbus_data == $past(r.acc_a[31:16]) + 16'h0001)
    else $error("conventional rounding did not increment");
  AST_ROUND_EVEN: assert property (op_a && op_code == dar_pkg::OP_STORE_ROUND &&
    !r.core_control_reg[dar_pkg::CC_ROUND_KIND] && !r.core_control_reg[dar_pkg::CC_STORE_CLIP] &&
    r.acc_a[16:0] == 17'h08000 |=> xbus_data == $past(r.acc_a[31:16]))
    else $error("convergent rounding incremented an even high word");
  AST_CLIP_POS: assert property (op_a && op_code == dar_pkg::OP_STORE &&
    r.core_control_reg[dar_pkg::CC_STORE_CLIP] && !r.acc_a[39] && r.acc_a[39:31] != 9'h000
    |=> xbus_data == dar_pkg::STORE_MAX)
    else $error("positive store clip missing");
  AST_STORE_KEEPS: assert property (op_valid && !use_adder |=> $stable(r.acc_a) && $stable(r.acc_b))
    else $error("store altered an accumulator");
  AST_WB_INC: assert property (op_valid && wb_ok && op_wb_mode == dar_pkg::WB_INDIRECT |=>
    xbus_addr == $past(r.wb_ptr) && writeback_pointer == $past(r.wb_ptr) + 16'h0002)
    else $error("indirect write-back address or increment wrong");
  AST_STATUS_OR: assert property (avs_read && avs_waitrequest && avs_address == dar_pkg::ADDR_STATUS
    |=> avs_readdata[5:4] == {$past(r.limit_hit_a | r.limit_hit_b),
    $past(r.guard_overflow_a | r.guard_overflow_b)})
    else $error("status OR bits wrong");
  COV_SAT931: cover property (op_a && clip_en && ov39 && r.core_control_reg[dar_pkg::CC_CLIP_WIDTH]);
  COV_SAT131: cover property (op_a && clip_en && ov31 && !r.core_control_reg[dar_pkg::CC_CLIP_WIDTH]);
  COV_WB: cover property (op_valid && wb_ok && op_wb_mode == dar_pkg::WB_INDIRECT);
  COV_CLEAR: cover property (clr_a && r.limit_hit_a);
endmodule : dar_accumulator

// >>> testbench/dsp_accumulator_saturate_round_tb_top.sv
// self-checking bench for the 40-bit accumulator datapath
`timescale 1ns/1ps
module dsp_accumulator_saturate_round_tb_top;
  logic clk;
  logic reset;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic op_valid;
  logic [3:0] op_code;
  logic op_target_b;
  logic [39:0] op_operand;
  logic op_scale;
  logic [5:0] op_shift;
  logic op_carry_in;
  logic [1:0] op_wb_mode;
  logic [15:0] op_addr;
  logic xbus_write;
  logic [15:0] xbus_addr;
  logic [15:0] xbus_data;
  logic [15:0] writeback_pointer;
  logic arith_trap;
  logic trap_seen;
  logic xw_seen;
  logic [31:0] rd_v;
  logic [39:0] acc_v;
  int fail_count;
  int n_compared;
  int cycles;
  // saturation rows: control, target, start value, subtract, result, status
  logic [7:0] s_ctrl [4] = '{8'h90, 8'h90, 8'h80, 8'h40};
  logic [3:0] s_tb = 4'b1000;
  logic [3:0] s_sub = 4'b1010;
  logic [39:0] s_ld [4] = '{40'h7fffffffff, 40'h8000000000, 40'h007fffffff, 40'hff80000000};
  logic [39:0] s_res [4] = '{40'h7fffffffff, 40'h8000000000, 40'h007fffffff, 40'h0080000000};
  logic [7:0] s_st [4] = '{8'h35, 8'h35, 8'h24, 8'h28};
  // store rows: control, accumulator, rounded store, expected word
  logic [7:0] r_ctrl [8] = '{8'h02, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h20, 8'h20};
  logic [39:0] r_acc [8] = '{40'h0012348000, 40'h0012348000, 40'h0012358000, 40'h0012347fff,
    40'h001234ffff, 40'h0100000000, 40'h0100000000, 40'hff00000000};
  logic [7:0] r_round = 8'b00001111;
  logic [15:0] r_exp [8] = '{16'h1235, 16'h1234, 16'h1236, 16'h1234,
    16'h1234, 16'h0000, 16'h7fff, 16'h8000};

  dar_accumulator dut_u (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_code(op_code),
    .op_target_b(op_target_b), .op_operand(op_operand), .op_scale(op_scale),
    .op_shift(op_shift), .op_carry_in(op_carry_in), .op_wb_mode(op_wb_mode),
    .op_addr(op_addr), .xbus_write(xbus_write), .xbus_addr(xbus_addr),
    .xbus_data(xbus_data), .writeback_pointer(writeback_pointer), .arith_trap(arith_trap)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rd(input logic [4:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  task rd_acc(input logic tb);
    rd(tb ? dar_pkg::ADDR_ACC_B_LO : dar_pkg::ADDR_ACC_A_LO);
    acc_v[31:0] = rd_v;
    rd(tb ? dar_pkg::ADDR_ACC_B_HI : dar_pkg::ADDR_ACC_A_HI);
    acc_v[39:32] = rd_v[7:0];
  endtask : rd_acc

  task op(input logic [3:0] c, input logic tb, input logic [39:0] v, input logic cin,
          input logic [1:0] wb, input logic [15:0] a);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_target_b <= tb;
    op_operand <= v;
    op_carry_in <= cin;
    op_wb_mode <= wb;
    op_addr <= a;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    trap_seen = arith_trap;
    xw_seen = xbus_write;
  endtask : op

  task ld(input logic tb, input logic [39:0] v);
    op(dar_pkg::OP_LOAD, tb, v, 1'b0, dar_pkg::WB_NONE, 16'h0000);
  endtask : ld

  initial begin
    reset = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {op_valid, op_code, op_target_b, op_operand, op_scale, op_shift} = '0;
    {op_carry_in, op_wb_mode, op_addr} = '0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    fork
      run_tests();
      begin
        while (cycles < 20000) begin
          @(posedge clk);
          cycles++;
        end
        fail_count++;
      end
    join_any
    report_and_stop();
  end

  task run_tests;
    rd(dar_pkg::ADDR_CORE_CTRL);
    chk("core_ctrl", 40'h0, {8'h00, rd_v});
    rd(dar_pkg::ADDR_WB_PTR);
    chk("wb_ptr", 40'h0, {8'h00, rd_v});
    bus(1'b1, dar_pkg::ADDR_ACC_A_LO, 32'h12345678);
    rd_acc(1'b0);
    chk("acc_a_read_only", 40'h0, acc_v);
    // scaled load: shift right by four
    op_scale <= 1'b1;
    op_shift <= 6'h04;
    ld(1'b0, 40'h0000000100);
    op_scale <= 1'b0;
    op_shift <= 6'h00;
    rd_acc(1'b0);
    chk("acc_scaled", 40'h10, acc_v);
    // clipping off: wrap, sticky limit, fatal trap
    bus(1'b1, dar_pkg::ADDR_TRAP_CTRL, 32'h4);
    ld(1'b0, 40'h7fffffffff);
    op(dar_pkg::OP_ADD, 1'b0, 40'h1, 1'b0, dar_pkg::WB_NONE, 16'h0);
    chk("fatal_trap", 40'h1, {39'h0, trap_seen});
    rd_acc(1'b0);
    chk("acc_wrap", 40'h8000000000, acc_v);
    rd(dar_pkg::ADDR_STATUS);
    chk("status_wrap", 40'h35, {8'h00, rd_v});
    ld(1'b0, 40'h10);
    op(dar_pkg::OP_SUB, 1'b0, 40'h3, 1'b0, dar_pkg::WB_NONE, 16'h0);
    rd_acc(1'b0);
    chk("acc_borrow", 40'hc, acc_v);
    rd(dar_pkg::ADDR_STATUS);
    chk("status_sticky", 40'h24, {8'h00, rd_v});
    bus(1'b1, dar_pkg::ADDR_STATUS, 32'h4);
    rd(dar_pkg::ADDR_STATUS);
    chk("status_cleared", 40'h0, {8'h00, rd_v});
    bus(1'b1, dar_pkg::ADDR_TRAP_CTRL, 32'h1);
    ld(1'b0, 40'h0100000000);
    chk("guard_trap", 40'h1, {39'h0, trap_seen});
    ld(1'b0, 40'h0);
    chk("guard_trap_quiet", 40'h0, {39'h0, trap_seen});
    bus(1'b1, dar_pkg::ADDR_TRAP_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, dar_pkg::ADDR_STATUS, 32'hc);
      bus(1'b1, dar_pkg::ADDR_CORE_CTRL, {24'h0, s_ctrl[i]});
      ld(s_tb[i], s_ld[i]);
      op(s_sub[i] ? dar_pkg::OP_SUB : dar_pkg::OP_ADD, s_tb[i], 40'h1, s_sub[i],
         dar_pkg::WB_NONE, 16'h0);
      rd_acc(s_tb[i]);
      chk("acc_saturated", s_res[i], acc_v);
      rd(dar_pkg::ADDR_STATUS);
      chk("status_saturated", {32'h0, s_st[i]}, {8'h00, rd_v});
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, dar_pkg::ADDR_CORE_CTRL, {24'h0, r_ctrl[i]});
      ld(1'b0, r_acc[i]);
      op(r_round[i] ? dar_pkg::OP_STORE_ROUND : dar_pkg::OP_STORE, 1'b0, 40'h0, 1'b0,
         dar_pkg::WB_NONE, 16'h0200 + 16'(2 * i));
      chk("store_pulse", 40'h1, {39'h0, xw_seen});
      chk("store_addr", {24'h0, 16'h0200 + 16'(2 * i)}, {24'h0, xbus_addr});
      chk("store_data", {24'h0, r_exp[i]}, {24'h0, xbus_data});
    end
    rd_acc(1'b0);
    chk("acc_after_clip", 40'hff00000000, acc_v);
    // write-back of the other accumulator
    bus(1'b1, dar_pkg::ADDR_CORE_CTRL, 32'h2);
    bus(1'b1, dar_pkg::ADDR_WB_PTR, 32'h0100);
    ld(1'b1, 40'h0012348000);
    ld(1'b0, 40'h0);
    op(dar_pkg::OP_MAC, 1'b0, 40'h0, 1'b0, dar_pkg::WB_INDIRECT, 16'h0);
    chk("wb_pulse", 40'h1, {39'h0, xw_seen});
    chk("wb_addr", 40'h0100, {24'h0, xbus_addr});
    chk("wb_data", 40'h1235, {24'h0, xbus_data});
    chk("wb_ptr_inc", 40'h0102, {24'h0, writeback_pointer});
    op(dar_pkg::OP_MAC, 1'b0, 40'h0, 1'b0, dar_pkg::WB_DIRECT, 16'h0);
    chk("wb_direct_pulse", 40'h0, {39'h0, xw_seen});
    chk("wb_direct_ptr", 40'h1235, {24'h0, writeback_pointer});
    op(dar_pkg::OP_PROD, 1'b0, 40'h0, 1'b0, dar_pkg::WB_INDIRECT, 16'h0);
    chk("wb_refused", 40'h0, {39'h0, xw_seen});
    chk("wb_refused_ptr", 40'h1235, {24'h0, writeback_pointer});
    // accumulator to accumulator, negate, clear with write-back
    op(dar_pkg::OP_ACC_ADD, 1'b0, 40'h0, 1'b0, dar_pkg::WB_NONE, 16'h0);
    rd_acc(1'b0);
    chk("acc_add_other", 40'h0012348000, acc_v);
    op(dar_pkg::OP_ACC_NEG, 1'b1, 40'h0, 1'b1, dar_pkg::WB_NONE, 16'h0);
    rd_acc(1'b1);
    chk("acc_negate", 40'hffedcb8000, acc_v);
    op(dar_pkg::OP_CLR, 1'b0, 40'h0, 1'b0, dar_pkg::WB_INDIRECT, 16'h0);
    chk("clr_wb_pulse", 40'h1, {39'h0, xw_seen});
    chk("clr_wb_data", 40'hedcc, {24'h0, xbus_data});
    chk("clr_wb_ptr", 40'h1237, {24'h0, writeback_pointer});
    rd_acc(1'b0);
    chk("acc_cleared", 40'h0, acc_v);
  endtask : run_tests
endmodule : dsp_accumulator_saturate_round_tb_top
